// [hw/ppmc_pkg.sv]
/*
 Constants for the read-only power-management capability header of one
 host-controller function: byte offsets, field positions, fixed values
 and the per-function capability words.
 Assumes a 32-bit configuration-read path that addresses whole dwords.
*/
`default_nettype none

package ppmc_pkg;

    // Byte offsets inside the capability dword
    localparam logic [1:0] OFS_IDENT = 2'h0;
    localparam logic [1:0] OFS_NEXT_PTR = 2'h1;
    localparam logic [1:0] OFS_CAP_WORD = 2'h2;

    // Fixed header bytes and the default capability base
    localparam logic [7:0] IDENT_VALUE = 8'h01;
    localparam logic [7:0] NEXT_PTR_VALUE = 8'h00;
    localparam logic [7:0] DEFAULT_CAP_BASE = 8'h40;

    // Field positions in the capabilities word
    localparam int PME_LSB = 11;
    localparam int PME_W = 5;
    localparam int PME_D3COLD_IDX = 4;
    localparam int D2_BIT = 10;
    localparam int D1_BIT = 9;
    localparam int AUX_LSB = 6;
    localparam int AUX_W = 3;
    localparam int DSI_BIT = 5;
    localparam int RSVD_BIT = 4;
    localparam int CLKDEP_BIT = 3;
    localparam int SPECREV_LSB = 0;
    localparam int SPECREV_W = 3;

    // Field values
    localparam logic [2:0] SPECREV_VALUE = 3'h2;
    localparam logic [2:0] AUX_NONE = 3'h0;
    localparam logic [2:0] AUX_100MA = 3'h2;
    localparam logic [4:0] PME_EHCI = 5'h1f;
    localparam logic [4:0] PME_OHCI = 5'h1a;
    localparam logic D2_EHCI = 1'b1;
    localparam logic D2_OHCI = 1'b0;
    localparam logic D1_ALL = 1'b1;
    localparam logic DSI_ALL = 1'b0;
    localparam logic CLKDEP_ALL = 1'b0;

    // Whole words and the bits that differ between functions
    localparam logic [15:0] WORD_EHCI = 16'hfe82;
    localparam logic [15:0] WORD_OHCI = 16'hd282;
    localparam logic [15:0] EHCI_ONLY_MASK = 16'h2c00;

    // Read answer latency in clock cycles
    localparam int ACK_LATENCY = 1;

endpackage

`default_nettype wire

// [hw/ppmc_regs.sv]
/*
 Power-management capability header of one host-controller function:
 identifier, next-capability pointer and capabilities word, all read-only,
 answering configuration reads and swallowing configuration writes.
 Assumes the configuration decoder presents one-cycle requests on i_mclk,
 with a dword-aligned capability base set by P_CAP_BASE.
*/

`timescale 1ns/100ps
`default_nettype none

module ppmc_regs #(
    parameter bit P_FUNC_IS_EHCI = 1'b1,
    parameter logic [7:0] P_CAP_BASE = ppmc_pkg::DEFAULT_CAP_BASE,
    parameter bit P_DATA_REG_IMPL = 1'b0,
    parameter logic [2:0] P_AUX_CURRENT = ppmc_pkg::AUX_100MA
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Configuration access
    input wire logic i_cfg_req,
    input wire logic i_cfg_we,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    output logic o_cfg_ack,
    output logic o_cfg_claim,
    output logic [31:0] o_cfg_rdata,
    // Decoded capability fields
    output logic [4:0] o_event_state_support,
    output logic o_deep_sleep_two_supported,
    output logic o_light_sleep_one_supported,
    output logic o_event_needs_bus_clock,
    output logic [2:0] o_pm_spec_version,
    output logic [15:0] o_power_capabilities_word
);

    // Per-function choices, fixed at build time
    localparam logic [4:0] PME_SEL = P_FUNC_IS_EHCI ? ppmc_pkg::PME_EHCI : ppmc_pkg::PME_OHCI;
    localparam logic D2_SEL = P_FUNC_IS_EHCI ? ppmc_pkg::D2_EHCI : ppmc_pkg::D2_OHCI;

    logic [4:0] pme_field;
    logic [2:0] aux_field;
    logic clkdep_field;
    logic [15:0] cap_word;
    logic [7:0] next_capability_pointer;
    logic [7:0] ident_byte;
    logic addr_hit;
    logic [31:0] read_dword;
    logic [31:0] lane_mask;

    // Field assembly
    always_comb begin
        pme_field = PME_SEL;
        // The data register and missing D3cold wake both silence the aux field
        if (P_DATA_REG_IMPL || !pme_field[ppmc_pkg::PME_D3COLD_IDX]) begin
            aux_field = ppmc_pkg::AUX_NONE;
        end else begin
            aux_field = P_AUX_CURRENT;
        end
        // No wake in any state forces the clock-dependence bit low
        if (pme_field == 5'h00) begin
            clkdep_field = 1'b0;
        end else begin
            clkdep_field = ppmc_pkg::CLKDEP_ALL;
        end
    end

    always_comb begin
        cap_word = 16'h0000;
        cap_word[ppmc_pkg::PME_LSB +: ppmc_pkg::PME_W] = pme_field;
        cap_word[ppmc_pkg::D2_BIT] = D2_SEL;
        cap_word[ppmc_pkg::D1_BIT] = ppmc_pkg::D1_ALL;
        cap_word[ppmc_pkg::AUX_LSB +: ppmc_pkg::AUX_W] = aux_field;
        cap_word[ppmc_pkg::DSI_BIT] = ppmc_pkg::DSI_ALL;
        cap_word[ppmc_pkg::RSVD_BIT] = 1'b0;
        cap_word[ppmc_pkg::CLKDEP_BIT] = clkdep_field;
        cap_word[ppmc_pkg::SPECREV_LSB +: ppmc_pkg::SPECREV_W] = ppmc_pkg::SPECREV_VALUE;
    end

    assign next_capability_pointer = ppmc_pkg::NEXT_PTR_VALUE;
    assign ident_byte = ppmc_pkg::IDENT_VALUE;

    // Dword decode; the base must be dword aligned for the header to fit one word
    always_comb begin
        if (i_cfg_addr[7:2] == P_CAP_BASE[7:2]) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end

    always_comb begin
        read_dword = 32'h0000_0000;
        read_dword[8 * ppmc_pkg::OFS_IDENT +: 8] = ident_byte;
        read_dword[8 * ppmc_pkg::OFS_NEXT_PTR +: 8] = next_capability_pointer;
        read_dword[8 * ppmc_pkg::OFS_CAP_WORD +: 16] = cap_word;
    end

    // Lanes not enabled read as zero
    always_comb begin
        lane_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    end

    // Answer one cycle after every request, read or write
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_cfg_ack <= 1'b0;
            o_cfg_claim <= 1'b0;
        end else begin
            o_cfg_ack <= i_cfg_req;
            o_cfg_claim <= i_cfg_req && addr_hit;
        end
    end

    // Writes never reach any storage: every field is a constant
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_cfg_rdata <= 32'h0000_0000;
        end else if (i_cfg_req && !i_cfg_we && addr_hit) begin
            o_cfg_rdata <= read_dword & lane_mask;
        end else begin
            o_cfg_rdata <= 32'h0000_0000;
        end
    end

    // Field outputs for the rest of the function
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_event_state_support <= 5'h00;
            o_deep_sleep_two_supported <= 1'b0;
            o_light_sleep_one_supported <= 1'b0;
            o_event_needs_bus_clock <= 1'b0;
            o_pm_spec_version <= 3'h0;
            o_power_capabilities_word <= 16'h0000;
        end else begin
            o_event_state_support <= pme_field;
            o_deep_sleep_two_supported <= cap_word[ppmc_pkg::D2_BIT];
            o_light_sleep_one_supported <= cap_word[ppmc_pkg::D1_BIT];
            o_event_needs_bus_clock <= cap_word[ppmc_pkg::CLKDEP_BIT];
            o_pm_spec_version <= cap_word[ppmc_pkg::SPECREV_LSB +: ppmc_pkg::SPECREV_W];
            o_power_capabilities_word <= cap_word;
        end
    end

    // Checks
    logic past_valid_reg;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            past_valid_reg <= 1'b0;
        end else begin
            past_valid_reg <= 1'b1;
        end
    end

    sequence s_full_read;
        i_cfg_req && !i_cfg_we && addr_hit && (i_cfg_be == 4'hf);
    endsequence

    sequence s_answer;
        o_cfg_ack && o_cfg_claim;
    endsequence

    // Misses still get an ack so the decoder never stalls on a dead dword
    sequence s_write_req;
        i_cfg_req && i_cfg_we;
    endsequence

    sequence s_miss_req;
        i_cfg_req && !addr_hit;
    endsequence

    sequence s_ptr_lane_read;
        i_cfg_req && !i_cfg_we && addr_hit && i_cfg_be[1];
    endsequence

    a_next_ptr_zero: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_full_read |-> ##1 (o_cfg_rdata[15:8] == 8'h00))
        else $error("Next pointer read nonzero");

    a_ptr_lane_pos: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_full_read |-> ##1 s_answer ##0 (o_cfg_rdata[15:8] == next_capability_pointer))
        else $error("Next pointer not in byte lane one");

    a_word_upper_half: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_full_read |-> ##1 (o_cfg_rdata[31:16] == o_power_capabilities_word))
        else $error("Capability word not two bytes past base");

    a_pme_field_map: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> (o_power_capabilities_word[15:11] == o_event_state_support))
        else $error("Event support field misplaced");

    a_pme_values: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> (o_event_state_support ==
            (P_FUNC_IS_EHCI ? 5'h1f : 5'h1a)))
        else $error("Event support bits wrong for function");

    a_d2_support: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> (o_deep_sleep_two_supported == P_FUNC_IS_EHCI)
            && (o_power_capabilities_word[10] == o_deep_sleep_two_supported))
        else $error("D2 support bit wrong");

    a_d1_support: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> o_light_sleep_one_supported && o_power_capabilities_word[9])
        else $error("D1 support bit wrong");

    a_aux_data_reg: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (past_valid_reg && P_DATA_REG_IMPL) |-> (o_power_capabilities_word[8:6] == 3'h0))
        else $error("Aux field nonzero with data register");

    a_aux_no_cold: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (past_valid_reg && !o_power_capabilities_word[15]) |->
            (o_power_capabilities_word[8:6] == 3'h0))
        else $error("Aux field nonzero without D3cold wake");

    a_aux_encoding: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (past_valid_reg && !P_DATA_REG_IMPL && o_power_capabilities_word[15]) |->
            (o_power_capabilities_word[8:6] == P_AUX_CURRENT))
        else $error("Aux current code not as configured");

    a_dsi_clear: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> !o_power_capabilities_word[5])
        else $error("Device init bit set");

    a_clkdep_clear: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> (o_event_needs_bus_clock == o_power_capabilities_word[3])
            && !o_event_needs_bus_clock)
        else $error("Clock dependence bit wrong");

    a_clkdep_no_wake: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (past_valid_reg && (o_event_state_support == 5'h00)) |-> !o_event_needs_bus_clock)
        else $error("Clock dependence set without wake support");

    a_version_val: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> (o_pm_spec_version == 3'h2)
            && (o_power_capabilities_word[2:0] == o_pm_spec_version))
        else $error("Version field wrong");

    a_func_diff: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> ((o_power_capabilities_word & ppmc_pkg::EHCI_ONLY_MASK) ==
            (P_FUNC_IS_EHCI ? ppmc_pkg::EHCI_ONLY_MASK : 16'h0000)))
        else $error("Function-specific bits wrong");

    a_ident_read: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_full_read |-> ##1 s_answer ##0 (o_cfg_rdata[7:0] == 8'h01))
        else $error("Identifier byte not 01h");

    a_word_const: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (past_valid_reg && !P_DATA_REG_IMPL && (P_AUX_CURRENT == 3'h2)) |->
            (o_power_capabilities_word ==
            (P_FUNC_IS_EHCI ? ppmc_pkg::WORD_EHCI : ppmc_pkg::WORD_OHCI)))
        else $error("Capability word not the fixed value");

    a_write_ignored: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (i_cfg_req && i_cfg_we) ##1 s_full_read |->
            ##1 (o_cfg_rdata == $past(read_dword)) && $stable(o_power_capabilities_word))
        else $error("Write changed read data");

    a_write_acked: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (i_cfg_req && i_cfg_we) |-> ##1 o_cfg_ack ##0 (o_cfg_rdata == 32'h0000_0000))
        else $error("Write not acknowledged");

    a_rsvd_zero: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_full_read |-> ##1 !o_cfg_rdata[20])
        else $error("Reserved bit reads one");

    a_ack_timing: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        !i_cfg_req |-> ##1 !o_cfg_ack && !o_cfg_claim && (o_cfg_rdata == 32'h0000_0000))
        else $error("Answer without request");

    a_ptr_lane_zero: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_ptr_lane_read |-> ##1 s_answer ##0 (o_cfg_rdata[15:8] == 8'h00))
        else $error("Next pointer lane read nonzero");

    a_write_claim: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_write_req |-> ##1 o_cfg_ack ##0 (o_cfg_claim == $past(addr_hit)))
        else $error("Write claim does not follow address");

    a_miss_silent: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        s_miss_req |-> ##1 o_cfg_ack ##0 !o_cfg_claim ##0 (o_cfg_rdata == 32'h0000_0000))
        else $error("Access outside the header answered with data");

    // Partial reads must not leak neighbouring fields into disabled lanes
    a_lane_masked: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (i_cfg_req && !i_cfg_we && addr_hit) |->
            ##1 ((o_cfg_rdata & ~$past(lane_mask)) == 32'h0000_0000))
        else $error("Disabled byte lane returned data");

    a_func_bits_read: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (i_cfg_req && !i_cfg_we && addr_hit && (i_cfg_be[3:2] == 2'h3)) |->
            ##1 ((o_cfg_rdata[31:16] & ppmc_pkg::EHCI_ONLY_MASK) ==
            (P_FUNC_IS_EHCI ? ppmc_pkg::EHCI_ONLY_MASK : 16'h0000)))
        else $error("Function-specific bits read wrong");

    a_version_read: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        (i_cfg_req && !i_cfg_we && addr_hit && i_cfg_be[2]) |->
            ##1 (o_cfg_rdata[18:16] == 3'h2))
        else $error("Version field read wrong");

    a_ack_after_req: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        i_cfg_req |-> ##1 o_cfg_ack)
        else $error("Request not acknowledged");

    a_word_stable: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        past_valid_reg |-> ##1 $stable(o_power_capabilities_word))
        else $error("Capability word changed");

endmodule

`default_nettype wire

// [tb/tb.sv]
/*
 Self-checking bench for the power-management capability header: three
 copies (EHCI, OHCI, OHCI with power data register) share one request bus.
 Assumes the one-cycle ack contract of the design and a base of 40h.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic [7:0] CAP_BASE = 8'h40;
    localparam bit EH [3] = '{1'b1, 1'b0, 1'b0};
    localparam bit DR [3] = '{1'b0, 1'b0, 1'b1};

    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic req = 1'b0;
    logic cwe = 1'b0;
    logic [7:0] caddr = 8'h00;
    logic [3:0] cbe = 4'h0;
    logic ack [3];
    logic claim [3];
    logic [31:0] rd [3];
    logic [4:0] ev [3];
    logic d2 [3];
    logic d1 [3];
    logic clk_dep [3];
    logic [2:0] spec_rev [3];
    logic [15:0] w [3];
    int n_errors = 0;
    int num_checks = 0;

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    for (genvar g = 0; g < 3; g++) begin : g_fn
        ppmc_regs #(
            .P_FUNC_IS_EHCI(EH[g]),
            .P_CAP_BASE(CAP_BASE),
            .P_DATA_REG_IMPL(DR[g]),
            .P_AUX_CURRENT(ppmc_pkg::AUX_100MA)
        ) ppmc_regs_inst (
            .i_mclk(i_mclk),
            .i_srst(i_srst),
            .i_cfg_req(req),
            .i_cfg_we(cwe),
            .i_cfg_addr(caddr),
            .i_cfg_be(cbe),
            .o_cfg_ack(ack[g]),
            .o_cfg_claim(claim[g]),
            .o_cfg_rdata(rd[g]),
            .o_event_state_support(ev[g]),
            .o_deep_sleep_two_supported(d2[g]),
            .o_light_sleep_one_supported(d1[g]),
            .o_event_needs_bus_clock(clk_dep[g]),
            .o_pm_spec_version(spec_rev[g]),
            .o_power_capabilities_word(w[g])
        );
    end

    // Word built field by field; data register forces aux current to 000b
    function automatic logic [15:0] exp_word(input int i);
        logic e;
        e = EH[i];
        return {1'b1, 1'b1, e, 1'b1, e, e, 1'b1, (DR[i] ? 3'h0 : 3'h2), 3'h0, 3'h2};
    endfunction

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
            n_errors++;
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Holds the request up so back-to-back calls need no idle cycle
    task automatic acc(input logic we, input logic [7:0] addr, input logic [3:0] be);
        logic hit;
        logic [31:0] m;
        req = 1'b1;
        cwe = we;
        caddr = addr;
        cbe = be;
        @(negedge i_mclk);
        hit = (addr[7:2] == CAP_BASE[7:2]);
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        for (int i = 0; i < 3; i++) begin
            chk(32'h1, {31'h0, ack[i]});
            chk({31'h0, hit}, {31'h0, claim[i]});
            chk((hit && !we) ? ({exp_word(i), 16'h0001} & m) : 32'h0, rd[i]);
        end
    endtask

    task automatic idle;
        req = 1'b0;
        cwe = 1'b0;
        @(negedge i_mclk);
        for (int i = 0; i < 3; i++) begin
            chk(32'h0, {30'h0, ack[i], claim[i]});
            chk(32'h0, rd[i]);
        end
    endtask

    task automatic t_reset;
        i_srst = 1'b1;
        repeat (4) @(negedge i_mclk);
        for (int i = 0; i < 3; i++) begin
            chk(32'h0, {16'h0, w[i]});
            chk(32'h0, {31'h0, ack[i]});
        end
        i_srst = 1'b0;
        @(negedge i_mclk);
        $display("test reset done");
    endtask

    task automatic t_fields;
        for (int i = 0; i < 3; i++) begin
            chk({16'h0, exp_word(i)}, {16'h0, w[i]});
            chk({27'h0, 1'b1, 1'b1, EH[i], 1'b1, EH[i]}, {27'h0, ev[i]});
            chk({31'h0, EH[i]}, {31'h0, d2[i]});
            chk(32'h1, {31'h0, d1[i]});
            chk(DR[i] ? 32'h0 : 32'h2, {29'h0, w[i][8:6]});
            chk(32'h0, {30'h0, w[i][5], w[i][4]});
            chk(32'h0, {31'h0, clk_dep[i]});
            chk(32'h2, {29'h0, spec_rev[i]});
        end
        chk(32'h2c00, {16'h0, w[0] ^ w[1]});
        $display("test fields done");
    endtask

    task automatic t_reads;
        acc(1'b0, 8'h40, 4'hf);
        acc(1'b0, 8'h42, 4'h3);
        acc(1'b0, 8'h41, 4'hc);
        acc(1'b0, 8'h40, 4'h2);
        idle();
        $display("test reads done");
    endtask

    // Writes are acked and claimed, yet the read-back must not move
    task automatic t_writes;
        acc(1'b1, 8'h40, 4'hf);
        acc(1'b1, 8'h41, 4'h2);
        acc(1'b1, 8'h42, 4'hc);
        acc(1'b0, 8'h40, 4'hf);
        idle();
        t_fields();
        $display("test writes done");
    endtask

    task automatic t_miss;
        acc(1'b0, 8'h44, 4'hf);
        acc(1'b0, 8'h3c, 4'hf);
        acc(1'b1, 8'h44, 4'hf);
        acc(1'b0, 8'h40, 4'hf);
        idle();
        $display("test miss done");
    endtask

    initial begin
        #20000;
        n_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        t_reset();
        t_fields();
        t_reads();
        t_writes();
        t_miss();
        t_reset();
        t_fields();
        t_reads();
        tally_and_finish();
    end
endmodule

`default_nettype wire
